//--- dv/mdcp_core_test.sv
// Self-checking bench for the motor drive control core against a reference model.
`default_nettype none
module mdcp_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    import mdcp_pkg::*;
    logic           clock = 1'b0;
    logic           sys_rst = 1'b1;
    logic [8:0]     analog_speed = '0;
    mdcp_sense_type sense = '0;
    logic [7:0]     current_sample = '0;
    logic [7:0]     supply_sample = '0;
    logic           nvm_load = 1'b0;
    mdcp_nvm_type   nvm_data = '0;
    mdcp_req_type   req;
    logic           speed_pin, dir_pin, rvalid, tach, vsel;
    logic [7:0]     rdata, d8;
    logic [2:0]     phase_pwm, phase_oe_n;
    logic [8:0]     duty, d9;
    int             bad_count = 0;
    int             samples_checked = 0;
    int             cycles = 0;
    int             n = 0;
    int             pwm_seen = 0;
    int             want = 0;
    logic           tach_was;
    int             exp_reg[int];
    always #4 clock = ~clock;
    mdcp_core #(.LOCK_OFF_CYCLES(20)) i_dut (
        .CLOCK(clock), .SYS_RST(sys_rst), .CLK_EN(1'b1), .SPEED_PIN(speed_pin),
        .ANALOG_SPEED(analog_speed), .DIR_PIN(dir_pin), .SENSE(sense),
        .CURRENT_SAMPLE(current_sample), .SUPPLY_SAMPLE(supply_sample),
        .NVM_LOAD(nvm_load), .NVM_DATA(nvm_data), .REQ(req), .RDATA(rdata),
        .RVALID(rvalid), .PHASE_PWM(phase_pwm), .PHASE_OE_N(phase_oe_n),
        .TACH_OUTPUT(tach), .REGULATOR_VOLTAGE_SELECT(vsel), .OUTPUT_PEAK_DUTY(duty)
    );
    mdcp_host_model i_host (
        .clock(clock), .rdata(rdata), .rvalid(rvalid), .req(req),
        .speed_pin(speed_pin), .dir_pin(dir_pin)
    );
    // ==========================================================
    // Reference model and comparison
    function automatic logic [7:0] status_model();
        return {sense.thermal, 1'b0, sense.overcurrent, sense.lock, 4'h0};
    endfunction : status_model
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic read_check(input logic [7:0] addr, input logic [7:0] want);
        logic [7:0] d;
        logic       ok;
        i_host.read_reg(addr, d, ok);
        check({7'h00, ok, d}, {8'h01, want});
    endtask : read_check
    // Writable registers are mirrored in the model; read-only ones are not.
    task automatic host_write(input logic [7:0] addr, input logic [7:0] data);
        i_host.write_reg(addr, data);
        if (addr inside {SPEED_LO_ADDR, SPEED_HI_ADDR, CONFIG_ADDR, LIMIT_ADDR}) begin
            exp_reg[addr] = data;
        end
    endtask : host_write
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc
    task automatic end_test(input string name);
        $display("test %s done at %0t", name, $time);
    endtask : end_test
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            finish_test();
        end
    end
    // ==========================================================
    // Scenarios
    initial begin
        void'($urandom(32'h7b73));
        cyc(2);
        check(16'(phase_oe_n), 16'h0007);
        sys_rst = 1'b0;
        sense.uv_high = 1'b1;
        read_check(FAULT_STATUS_ADDR, status_model());
        i_host.write_reg(FAULT_STATUS_ADDR, 8'hff);
        read_check(FAULT_STATUS_ADDR, status_model());
        read_check(8'h3c, 8'h00);
        end_test("status");
        for (int k = 0; k < 2; k++) begin
            if (k == 1) sense.overcurrent = 1'b1;
            else sense.thermal = 1'b1;
            cyc(3);
            check(16'(phase_oe_n), 16'h0007);
            check(16'(phase_pwm), 16'h0000);
            read_check(FAULT_STATUS_ADDR, status_model());
            sense = '{uv_high: 1'b1, default: '0};
            cyc(3);
            check(16'(phase_oe_n), 16'h0000);
            read_check(FAULT_STATUS_ADDR, status_model());
        end
        end_test("thermal and overcurrent");
        sense.lock = 1'b1;
        sense.lock_cause = 3'($urandom_range(7, 1));
        cyc(3);
        read_check(FAULT_STATUS_ADDR, status_model());
        read_check(FAULT_CAUSE_ADDR, {5'h00, sense.lock_cause});
        sense.lock = 1'b0;
        check(16'(phase_oe_n), 16'h0007);
        cyc(60);
        check(16'(phase_oe_n), 16'h0000);
        read_check(FAULT_STATUS_ADDR, status_model());
        end_test("rotor lock");
        for (int s = 0; s < 6; s++) begin
            d8 = {5'h00, 1'(s % 2), 2'(s / 2)};
            host_write(CONFIG_ADDR, d8);
            cyc(2);
            check(16'(vsel), 16'(d8[CFG_VREG_BIT]));
            read_check(CONFIG_ADDR, 8'(exp_reg[CONFIG_ADDR]));
        end
        repeat (4) begin
            d9 = 9'($urandom);
            host_write(SPEED_LO_ADDR, d9[7:0]);
            host_write(SPEED_HI_ADDR, {7'h00, d9[8]});
            read_check(SPEED_LO_ADDR, 8'(exp_reg[SPEED_LO_ADDR]));
            read_check(SPEED_HI_ADDR, 8'(exp_reg[SPEED_HI_ADDR]));
        end
        end_test("config and speed");
        nvm_data = '{config_v: 8'h05, speed: 9'($urandom), limit: 8'($urandom)};
        nvm_load = 1'b1;
        cyc(1);
        nvm_load = 1'b0;
        exp_reg[CONFIG_ADDR] = nvm_data.config_v;
        exp_reg[SPEED_LO_ADDR] = nvm_data.speed[7:0];
        exp_reg[SPEED_HI_ADDR] = {7'h00, nvm_data.speed[8]};
        exp_reg[LIMIT_ADDR] = nvm_data.limit;
        foreach (exp_reg[a]) begin
            read_check(8'(a), 8'(exp_reg[a]));
        end
        host_write(SPEED_LO_ADDR, ~nvm_data.speed[7:0]);
        read_check(SPEED_LO_ADDR, 8'(exp_reg[SPEED_LO_ADDR]));
        end_test("stored settings");
        current_sample = 8'($urandom);
        supply_sample = 8'($urandom_range(255, 128));
        analog_speed = 9'($urandom);
        d9 = 9'($urandom_range(511, 256));
        host_write(LIMIT_ADDR, 8'($urandom_range(127, 64)));
        host_write(SPEED_LO_ADDR, d9[7:0]);
        host_write(SPEED_HI_ADDR, {7'h00, d9[8]});
        host_write(CONFIG_ADDR, 8'h00);
        i_host.set_pins(1'b0, 1'b1);
        // A half-duty pulse train measures at or above any limit cap used here.
        cyc(1100);
        check(16'(duty), 16'(2 * exp_reg[LIMIT_ADDR] + 1));
        read_check(CURRENT_ADDR, current_sample);
        read_check(SUPPLY_ADDR, supply_sample);
        host_write(CONFIG_ADDR, 8'h02);
        cyc(3);
        want = d9;
        if (want > 2 * exp_reg[LIMIT_ADDR] + 1) want = 2 * exp_reg[LIMIT_ADDR] + 1;
        if (want > 2 * supply_sample + 1) want = 2 * supply_sample + 1;
        check(16'(duty), 16'(want));
        read_check(DUTY_ADDR, 8'(want >> 1));
        for (int m = 0; m < 2; m++) begin
            n = 0;
            tach_was = tach;
            while (tach === tach_was && n < 5000) begin
                cyc(1);
                n++;
                if (phase_pwm != 3'h0) pwm_seen++;
                check(16'(phase_pwm == 3'h7), 16'h0000);
            end
        end
        check(16'(n), 16'(SIN_STEPS / 8 * PWM_PERIOD_CYC));
        check(16'(pwm_seen > 0), 16'h0001);
        i_host.set_pins(1'b1, 1'b0);
        end_test("samples and pins");
        finish_test();
    end
endmodule : mdcp_core_test
`default_nettype wire

//--- dv/mdcp_host_model.sv
// Host controller model: register port requests, speed pulse pin and direction pin.
`default_nettype none
module mdcp_host_model
    import mdcp_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic [7:0]            rdata,
    input  wire logic                  rvalid,
    output var  mdcp_pkg::mdcp_req_type req,
    output var  logic                  speed_pin,
    output var  logic                  dir_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pwm_run = 1'b0;
    initial begin
        req = '0;
        dir_pin = 1'b1;
        speed_pin = 1'b0;
    end
    // ==========================================================
    // Speed pulse train
    // The pin stands low whenever the host is not sending pulses.
    always begin
        #32;
        speed_pin = pwm_run ? ~speed_pin : 1'b0;
    end
    // ==========================================================
    // Register port
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clock);
        req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(negedge clock);
        req = '0;
        @(negedge clock);
    endtask : write_reg
    // The answer is taken at the first falling edge where the valid pulse shows.
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic seen);
        @(negedge clock);
        req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(negedge clock);
        req = '0;
        seen = 1'b0;
        data = 8'h00;
        for (int i = 0; i < 4 && !seen; i++) begin
            if (rvalid === 1'b1) begin
                seen = 1'b1;
                data = rdata;
            end else begin
                @(negedge clock);
            end
        end
    endtask : read_reg
    task automatic set_pins(input logic fwd, input logic run);
        @(negedge clock);
        dir_pin = fwd;
        pwm_run = run;
    endtask : set_pins
endmodule : mdcp_host_model
`default_nettype wire

//--- verilog/mdcp_core.sv
// Motor drive control core: speed select, duty, modulation, protection, registers.
`default_nettype none
module mdcp_core
    import mdcp_pkg::*;
#(
    parameter int LOCK_OFF_CYCLES = LOCK_OFF_CYC
) (
    input  wire logic                    CLOCK,
    input  wire logic                    SYS_RST,
    input  wire logic                    CLK_EN,
    input  wire logic                    SPEED_PIN,
    input  wire logic [8:0]              ANALOG_SPEED,
    input  wire logic                    DIR_PIN,
    input  wire mdcp_pkg::mdcp_sense_type SENSE,
    input  wire logic [7:0]              CURRENT_SAMPLE,
    input  wire logic [7:0]              SUPPLY_SAMPLE,
    input  wire logic                    NVM_LOAD,
    input  wire mdcp_pkg::mdcp_nvm_type  NVM_DATA,
    input  wire mdcp_pkg::mdcp_req_type  REQ,
    output logic [7:0]                   RDATA,
    output logic                         RVALID,
    output logic [2:0]                   PHASE_PWM,
    output logic [2:0]                   PHASE_OE_N,
    output logic                         TACH_OUTPUT,
    output logic                         REGULATOR_VOLTAGE_SELECT,
    output logic [8:0]                   OUTPUT_PEAK_DUTY
);
    import mdcp_pkg::*;

    // ==========================================================
    // Input synchronisers
    logic [1:0] spd_s_r, dir_s_r;
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            spd_s_r <= 2'h0;
            dir_s_r <= 2'h0;
        end else if (CLK_EN) begin
            spd_s_r <= {spd_s_r[0], SPEED_PIN};
            dir_s_r <= {dir_s_r[0], DIR_PIN};
        end
    end
    wire logic spd_pin = spd_s_r[1];
    wire logic dir_fwd = dir_s_r[1];

    // ==========================================================
    // Working registers
    logic [7:0] config_r;
    logic [8:0] speed_command_value_r;
    logic [7:0] limit_r;
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            config_r              <= CONFIG_RST;
            speed_command_value_r <= SPEED_RST;
            limit_r               <= LIMIT_RST;
        end else if (CLK_EN) begin
            if (NVM_LOAD) begin
                config_r              <= NVM_DATA.config_v;
                speed_command_value_r <= NVM_DATA.speed;
                limit_r               <= NVM_DATA.limit;
            end else if (REQ.wr) begin
                case (REQ.addr)
                    SPEED_LO_ADDR: speed_command_value_r[7:0] <= REQ.wdata;
                    SPEED_HI_ADDR: speed_command_value_r[8]   <= REQ.wdata[0];
                    CONFIG_ADDR:   config_r                   <= REQ.wdata;
                    LIMIT_ADDR:    limit_r                    <= REQ.wdata;
                    default: ;
                endcase
            end
        end
    end
    wire mdcp_src_type src = mdcp_src_type'(config_r[CFG_SRC_LSB +: 2]);

    // ==========================================================
    // Pulse width capture of the speed pin
    logic [8:0] pw_cnt_r, pw_high_r, pw_cmd_r;
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            pw_cnt_r  <= 9'h000;
            pw_high_r <= 9'h000;
            pw_cmd_r  <= 9'h000;
        end else if (CLK_EN) begin
            if (pw_cnt_r == 9'(PWM_PERIOD_CYC - 1)) begin
                pw_cnt_r  <= 9'h000;
                pw_cmd_r  <= pw_high_r;
                pw_high_r <= 9'h000;
            end else begin
                pw_cnt_r <= pw_cnt_r + 9'h001;
                if (spd_pin && pw_high_r != 9'h1ff)
                    pw_high_r <= pw_high_r + 9'h001;
            end
        end
    end

    // Analog level sampled once per sample period.
    logic [15:0] ana_cnt_r;
    logic [8:0]  ana_cmd_r;
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            ana_cnt_r <= 16'h0000;
            ana_cmd_r <= 9'h000;
        end else if (CLK_EN) begin
            if (ana_cnt_r == 16'(ANA_SAMPLE_CYC - 1)) begin
                ana_cnt_r <= 16'h0000;
                ana_cmd_r <= ANALOG_SPEED;
            end else begin
                ana_cnt_r <= ana_cnt_r + 16'h0001;
            end
        end
    end

    // ==========================================================
    // Speed command select and duty limiting
    logic [8:0] cmd;
    always_comb begin
        case (src)
            SRC_PWM:    cmd = pw_cmd_r;
            SRC_ANALOG: cmd = ana_cmd_r;
            SRC_SERIAL: cmd = speed_command_value_r;
            default:    cmd = 9'h000;
        endcase
    end
    // The limit register and supply sample cap the duty below the command.
    wire logic [8:0] lim_cap = {limit_r, 1'b1};
    wire logic [8:0] sup_cap = {SUPPLY_SAMPLE, 1'b1};
    logic [8:0] duty_r;
    always_ff @(posedge CLOCK) begin
        if (SYS_RST)
            duty_r <= 9'h000;
        else if (CLK_EN) begin
            if (cmd > lim_cap && lim_cap <= sup_cap)
                duty_r <= lim_cap;
            else if (cmd > sup_cap)
                duty_r <= sup_cap;
            else
                duty_r <= cmd;
        end
    end

    // ==========================================================
    // Protection
    logic uv_lock_r;
    logic lock_off_r;
    logic [31:0] lock_cnt_r;
    logic [2:0] fault_cause_register_r;
    always_ff @(posedge CLOCK) begin
        if (SYS_RST)
            uv_lock_r <= 1'b1;
        else if (CLK_EN) begin
            if (SENSE.uv_low)
                uv_lock_r <= 1'b1;
            else if (SENSE.uv_high)
                uv_lock_r <= 1'b0;
        end
    end
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            lock_off_r <= 1'b0;
            lock_cnt_r <= 32'h0;
        end else if (CLK_EN) begin
            if (!lock_off_r && SENSE.lock) begin
                lock_off_r <= 1'b1;
                lock_cnt_r <= 32'(LOCK_OFF_CYCLES - 1);
            end else if (lock_off_r) begin
                if (lock_cnt_r == 32'h0)
                    lock_off_r <= 1'b0;
                else
                    lock_cnt_r <= lock_cnt_r - 32'h1;
            end
        end
    end
    always_ff @(posedge CLOCK) begin
        if (SYS_RST)
            fault_cause_register_r <= 3'h0;
        else if (CLK_EN && SENSE.lock)
            fault_cause_register_r <= SENSE.lock_cause;
    end
    wire logic halt = SENSE.thermal | uv_lock_r | lock_off_r;
    wire logic [7:0] fault_status = {SENSE.thermal, 1'b0, SENSE.overcurrent,
                                     lock_off_r | SENSE.lock, 4'h0};

    // ==========================================================
    // Three-phase triangular modulation
    function automatic logic [7:0] wave(input logic [5:0] ph);
        logic [5:0] p;
        logic [7:0] v;
        p = ph;
        if (p >= 6'd42)
            v = 8'h00;
        else if (p < 6'd21)
            v = 8'((p * 12) > 255 ? 255 : p * 12);
        else
            v = 8'((6'd41 - p) * 12 > 255 ? 255 : (6'd41 - p) * 12);
        return v;
    endfunction
    logic [5:0]  elec_r;
    logic [8:0]  carrier_r;
    logic [2:0]  pwm_r;
    wire logic [2:0] pwm_nxt;
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            elec_r    <= 6'h00;
            carrier_r <= 9'h000;
        end else if (CLK_EN) begin
            carrier_r <= carrier_r + 9'h001;
            if (carrier_r == 9'h1ff && !halt) begin
                if (dir_fwd)
                    elec_r <= elec_r + 6'h01;
                else
                    elec_r <= elec_r - 6'h01;
            end
        end
    end
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_phase
            wire logic [5:0] ph = 6'(elec_r + 6'(g * 21));
            wire logic [16:0] lvl = wave(ph) * duty_r;
            assign pwm_nxt[g] = !halt && (carrier_r < lvl[16:8]);
        end
    endgenerate
    always_ff @(posedge CLOCK) begin
        if (SYS_RST)
            pwm_r <= 3'h0;
        else if (CLK_EN)
            pwm_r <= pwm_nxt;
    end

    // ==========================================================
    // Outputs
    logic tach_r;
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            PHASE_PWM                <= 3'h0;
            PHASE_OE_N               <= 3'h7;
            tach_r                   <= 1'b0;
            REGULATOR_VOLTAGE_SELECT <= 1'b0;
            OUTPUT_PEAK_DUTY         <= 9'h000;
        end else if (CLK_EN) begin
            PHASE_PWM  <= pwm_r;
            PHASE_OE_N <= (SENSE.overcurrent || halt) ? 3'h7 : 3'h0;
            if (carrier_r == 9'h1ff && !halt && elec_r[2:0] == 3'h0)
                tach_r <= ~tach_r;
            REGULATOR_VOLTAGE_SELECT <= config_r[CFG_VREG_BIT];
            OUTPUT_PEAK_DUTY         <= duty_r;
        end
    end
    assign TACH_OUTPUT = tach_r;

    // ==========================================================
    // Register read port
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            RDATA  <= 8'h00;
            RVALID <= 1'b0;
        end else if (CLK_EN) begin
            RVALID <= REQ.rd;
            case (REQ.addr)
                FAULT_STATUS_ADDR: RDATA <= fault_status;
                FAULT_CAUSE_ADDR:  RDATA <= {5'h00, fault_cause_register_r};
                SPEED_LO_ADDR:     RDATA <= speed_command_value_r[7:0];
                SPEED_HI_ADDR:     RDATA <= {7'h00, speed_command_value_r[8]};
                CONFIG_ADDR:       RDATA <= config_r;
                CURRENT_ADDR:      RDATA <= CURRENT_SAMPLE;
                SUPPLY_ADDR:       RDATA <= SUPPLY_SAMPLE;
                DUTY_ADDR:         RDATA <= duty_r[8:1];
                LIMIT_ADDR:        RDATA <= limit_r;
                default:           RDATA <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // Checks
    property p_oc_hiz;
        @(posedge CLOCK) disable iff (SYS_RST) CLK_EN && SENSE.overcurrent |=> PHASE_OE_N == 3'h7;
    endproperty
    a_oc_hiz: assert property (p_oc_hiz) else $error("overcurrent did not tristate");
    property p_therm_off;
        @(posedge CLOCK) disable iff (SYS_RST) CLK_EN && SENSE.thermal |=> pwm_r == 3'h0;
    endproperty
    a_therm_off: assert property (p_therm_off) else $error("thermal did not stop drive");
    property p_lock_stop;
        @(posedge CLOCK) disable iff (SYS_RST) CLK_EN && SENSE.lock && !lock_off_r |=> lock_off_r;
    endproperty
    a_lock_stop: assert property (p_lock_stop) else $error("lock did not stop drive");
    property p_uv;
        @(posedge CLOCK) disable iff (SYS_RST) CLK_EN && SENSE.uv_low |=> uv_lock_r;
    endproperty
    a_uv: assert property (p_uv) else $error("undervoltage not locked");
    property p_vreg;
        @(posedge CLOCK) disable iff (SYS_RST)
            CLK_EN |=> REGULATOR_VOLTAGE_SELECT == $past(config_r[CFG_VREG_BIT]);
    endproperty
    a_vreg: assert property (p_vreg) else $error("regulator select mismatch");
    property p_status;
        @(posedge CLOCK) disable iff (SYS_RST)
            CLK_EN && REQ.rd && REQ.addr == FAULT_STATUS_ADDR |=> RDATA[THERMAL_BIT] == $past(SENSE.thermal);
    endproperty
    a_status: assert property (p_status) else $error("status bit 7 wrong");
    property p_duty_cap;
        @(posedge CLOCK) disable iff (SYS_RST)
            (duty_r <= lim_cap && duty_r <= sup_cap) || !$past(CLK_EN)
            || $changed(limit_r) || $changed(SUPPLY_SAMPLE);
    endproperty
    a_duty_cap: assert property (p_duty_cap) else $error("duty above limits");
    property p_nvm;
        @(posedge CLOCK) disable iff (SYS_RST) CLK_EN && NVM_LOAD |=> config_r == $past(NVM_DATA.config_v);
    endproperty
    a_nvm: assert property (p_nvm) else $error("nvm load missed");
    c_lock: cover property (@(posedge CLOCK) disable iff (SYS_RST) $fell(lock_off_r));
    c_oc: cover property (@(posedge CLOCK) disable iff (SYS_RST) SENSE.overcurrent);
    c_tach: cover property (@(posedge CLOCK) disable iff (SYS_RST) $rose(tach_r));
endmodule : mdcp_core
`default_nettype wire

//--- verilog/mdcp_pkg.sv
// Package of constants and types for the motor drive control core.
`default_nettype none
package mdcp_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] FAULT_STATUS_ADDR   = 8'h10;
    localparam logic [7:0] FAULT_CAUSE_ADDR    = 8'h11;
    localparam logic [7:0] SPEED_LO_ADDR       = 8'h12;
    localparam logic [7:0] SPEED_HI_ADDR       = 8'h13;
    localparam logic [7:0] CONFIG_ADDR         = 8'h14;
    localparam logic [7:0] CURRENT_ADDR        = 8'h15;
    localparam logic [7:0] SUPPLY_ADDR         = 8'h16;
    localparam logic [7:0] DUTY_ADDR           = 8'h17;
    localparam logic [7:0] LIMIT_ADDR          = 8'h18;
    // ==========================================================
    // Field positions
    localparam int THERMAL_BIT  = 7;
    localparam int SLEEP_BIT    = 6;
    localparam int OVERCUR_BIT  = 5;
    localparam int LOCK_BIT     = 4;
    localparam int CFG_SRC_LSB  = 0;
    localparam int CFG_VREG_BIT = 2;
    // ==========================================================
    // Reset values
    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [8:0] SPEED_RST  = 9'h000;
    localparam logic [7:0] LIMIT_RST  = 8'hff;
    // ==========================================================
    // Timing at 125 MHz
    localparam int CLK_MHZ        = 125;
    localparam int LOCK_OFF_MS    = 5000;
    localparam int LOCK_OFF_CYC   = LOCK_OFF_MS * CLK_MHZ * 1000;
    localparam int PWM_PERIOD_CYC = 512;
    localparam int SIN_STEPS      = 64;
    localparam int ANA_SAMPLE_US  = 320;
    localparam int ANA_SAMPLE_CYC = ANA_SAMPLE_US * CLK_MHZ;
    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        SRC_PWM,
        SRC_ANALOG,
        SRC_SERIAL
    } mdcp_src_type;
    typedef struct packed {
        logic thermal;
        logic uv_low;
        logic uv_high;
        logic overcurrent;
        logic lock;
        logic [2:0] lock_cause;
    } mdcp_sense_type;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mdcp_req_type;
    typedef struct packed {
        logic [7:0] config_v;
        logic [8:0] speed;
        logic [7:0] limit;
    } mdcp_nvm_type;
endpackage : mdcp_pkg
`default_nettype wire
